// [dv/dcto_estop.sv]
/* Emergency stop switch model driving both channels.
   Assumes press changes just after a rising edge. */
`timescale 1ns/1ps
module dcto_estop (
    input wire logic       clk,
    input wire logic       press,
    input wire logic [7:0] lag,
    input wire logic       one_side,
    output logic           chan_a,
    output logic           chan_b
);
    logic [7:0] held;
    // Presses stay short, so the counter never wraps.
    always_ff @(posedge clk)
        held <= press ? held + 8'h1 : 8'h0;
    assign chan_a = ~press;
    assign chan_b = ~(press & (held >= lag) & ~one_side);
endmodule // dcto_estop

// [dv/dcto_sto_monitor.sv]
/* Port checker for dcto_monitor: assertions and covers on its pins.
   Assumes it is bound to dcto_monitor and sees only that module's ports. */
`timescale 1ns/1ps
module dcto_port_monitor #(
    parameter int unsigned DISCREPANCY_CYCLES = 20
) (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       torque_off_input_a,
    input wire logic       torque_off_input_b,
    input wire logic       auto_power_enable,
    input wire logic       enable_request,
    input wire logic       power_stage_enable,
    input wire logic       safe_torque_off,
    input wire logic       error_detected,
    input wire logic [2:0] error_class
);
    localparam int LIM = DISCREPANCY_CYCLES + 3;
    wire       lo   = ~torque_off_input_a | ~torque_off_input_b;
    wire       both = ~torque_off_input_a & ~torque_off_input_b;
    wire       hold = ~enable_request & ~auto_power_enable;
    wire       pe   = power_stage_enable;
    wire [2:0] ec   = error_class;
    logic      pr;
    int        cnt;
    // A seen pair must stop the count, or a late return high would read as skew.
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n) pr <= 1'b0;
        else pr <= both | (pr & (ec != 3'h0));
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n) cnt <= 0;
        else cnt <= (ec == 3'h3 && !both && !pr) ? cnt + 1 : 0;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_low_cuts_power: assert property (lo |-> !pe) else $error("stage on");
    a_off_inverse: assert property (safe_torque_off == !pe) else $error("inverse");
    a_class_three: assert property (pe ##1 lo |=> ec == 3'h3) else $error("no 3");
    a_flag_tracks: assert property (error_detected == (ec != 3'h0)) else $error("flag");
    a_pair_keeps: assert property (ec == 3'h3 && both |=> ec == 3'h3) else $error("pair");
    a_skew_bound: assert property (cnt <= LIM) else $error("no 4");
    a_skew_early: assert property ($rose(ec == 3'h4) |-> cnt >= LIM - 5) else $error("early");
    a_stop_latched: assert property (!pe && hold |=> !pe) else $error("restart");
    a_four_latched: assert property (ec == 3'h4 && hold |=> ec == 3'h4) else $error("lost");
    cover property (ec == 3'h4);
    cover property (both && ec == 3'h3);
    cover property ($rose(pe));
endmodule // dcto_port_monitor

// [dv/tb_dual_channel_torque_off.sv]
/* Bench for dcto_monitor with a switch model.
   Assumes a 20 cycle skew limit. */
`timescale 1ns/1ps
module tb_dual_channel_torque_off;
    logic       clk, arst_n, press, one_side, auto_en, req, ch_a, ch_b, pse, tq_off, det;
    logic [7:0] lag;
    logic [2:0] cls;
    int         err_total, num_checks;
    dcto_estop u_sw (.clk(clk), .press(press), .lag(lag), .one_side(one_side),
        .chan_a(ch_a), .chan_b(ch_b));
    dcto_monitor #(.DISCREPANCY_CYCLES(20)) DUT (.clk(clk), .arst_n(arst_n),
        .torque_off_input_a(ch_a), .torque_off_input_b(ch_b), .auto_power_enable(auto_en),
        .enable_request(req), .power_stage_enable(pse), .safe_torque_off(tq_off),
        .error_detected(det), .error_class(cls));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [2:0] s, input logic [2:0] e);
        num_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic restart(input logic use_auto);
        int n;
        check(3'(pse), 3'h0);
        @(posedge clk) req <= ~use_auto;
        auto_en <= use_auto;
        for (n = 0; n < 20 && pse !== 1'b1; n++)
            @(negedge clk);
        if (n == 20)
        begin
            err_total++;
            conclude();
        end
        check(cls, 3'h0);
        @(posedge clk) req <= 1'b0;
    endtask
    task automatic stop(input logic one, input logic [7:0] lg, input logic [2:0] e);
        restart(1'b0);
        @(posedge clk) press <= 1'b1;
        one_side <= one;
        lag <= lg;
        @(negedge clk);
        check(3'(pse), 3'h0);
        check(3'(tq_off), 3'h1);
        repeat (30) @(negedge clk);
        check(cls, e);
        check(3'(det), 3'h1);
        // A request while a channel is still low must be refused.
        @(posedge clk) req <= 1'b1;
        @(posedge clk) req <= 1'b0;
        @(negedge clk);
        check(3'(pse), 3'h0);
        check(cls, e);
        @(posedge clk) press <= 1'b0;
        repeat (5) @(negedge clk);
        check(3'(pse), 3'h0);
        $display("stop test done");
    endtask
    task automatic reset_run;
        restart(1'b0);
        @(posedge clk) arst_n <= 1'b0;
        @(negedge clk);
        check(3'(pse), 3'h0);
        check(3'(tq_off), 3'h1);
        check(cls, 3'h0);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(negedge clk);
        check(3'(pse), 3'h0);
        $display("reset test done");
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        {arst_n, press, one_side, auto_en, req, lag} = '0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(negedge clk);
        stop(1'b0, 8'h3, 3'h3);
        stop(1'b0, 8'h0, 3'h3);
        stop(1'b1, 8'h3, 3'h4);
        stop(1'b0, 8'hf, 3'h3);
        reset_run();
        restart(1'b1);
        $display("auto restart test done");
        conclude();
    end
endmodule // tb_dual_channel_torque_off
bind dcto_monitor dcto_port_monitor #(.DISCREPANCY_CYCLES(DISCREPANCY_CYCLES)) u_chk (
    .clk(clk), .arst_n(arst_n), .torque_off_input_a(torque_off_input_a),
    .torque_off_input_b(torque_off_input_b), .auto_power_enable(auto_power_enable),
    .enable_request(enable_request), .power_stage_enable(power_stage_enable),
    .safe_torque_off(safe_torque_off), .error_detected(error_detected),
    .error_class(error_class));

// [src/dcto_monitor.sv]
/*
 Dual-channel torque-off monitor. Drives the power stage enable and reports
 the error class.
 Assumes both torque-off inputs are already synchronous to clk and that the
 power stage gating is the only thing this block switches off.
*/
`timescale 1ns/1ps
module dcto_monitor #(
    parameter int unsigned DISCREPANCY_CYCLES = dcto_pkg::DISCREPANCY_CYC
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       torque_off_input_a,
    input  wire logic       torque_off_input_b,
    input  wire logic       auto_power_enable,
    input  wire logic       enable_request,
    output logic            power_stage_enable,
    output logic            safe_torque_off,
    output logic            error_detected,
    output logic [2:0]      error_class
);
    import dcto_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // Input decode
    // ------------------------------------------------------------------
    // High permits operation, low requests a stop.
    wire any_low  = !torque_off_input_a || !torque_off_input_b;
    wire both_low = !torque_off_input_a && !torque_off_input_b;
    wire both_hi  = torque_off_input_a && torque_off_input_b;

    dcto_state_t state;
    dcto_state_t next_state;
    logic [2:0]  next_class;
    logic        timer_expired;

    wire timer_clear = (state != DCTO_WAIT);

    dcto_timer #(
        .WIDTH (TIMER_W),
        .LIMIT (DISCREPANCY_CYCLES)
    ) u_timer (
        .clk     (clk),
        .rst_n   (rst_n),
        .clear   (timer_clear),
        .expired (timer_expired)
    );

    // Re-enable needs both channels high plus a request or auto enabling.
    wire restart = both_hi && (enable_request || auto_power_enable);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_class = error_class;
        case (state)
            DCTO_RUN:
            begin
                if (any_low)
                begin
                    next_class = ERR_CLASS_STOP;
                    next_state = both_low ? DCTO_STOPPED : DCTO_WAIT;
                end
            end
            DCTO_WAIT:
            begin
                if (both_low)
                    next_state = DCTO_STOPPED;
                else if (timer_expired)
                begin
                    next_class = ERR_CLASS_DISCREP;
                    next_state = DCTO_STOPPED;
                end
            end
            DCTO_STOPPED:
            begin
                if (restart)
                begin
                    next_class = ERR_CLASS_NONE;
                    next_state = DCTO_RUN;
                end
            end
            default:
            begin
                next_state = DCTO_STOPPED;
                next_class = ERR_CLASS_DISCREP;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state       <= DCTO_STOPPED;
            error_class <= ERR_CLASS_NONE;
        end
        else
        begin
            state       <= next_state;
            error_class <= next_class;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The enable drops combinationally with either input so the cut does
    // not wait a cycle, and nothing waits for a brake. Only winding power
    // is gated; no bus or supply control and no brake output exist here.
    assign power_stage_enable = (state == DCTO_RUN) && !any_low;
    assign safe_torque_off    = !power_stage_enable;
    assign error_detected     = (error_class != ERR_CLASS_NONE);

endmodule // dcto_monitor

// [src/dcto_pkg.sv]
/*
 Package for the dual-channel torque-off monitor: error classes, timing
 constants and the monitor state encoding.
 Assumes a single 25 MHz clock shared by every user of the package.
*/
// Contract
// - Either input low triggers torque-off at once; no wait for both.
// - Power stage disabled immediately on trigger, brake not awaited; motor coasts.
// - A trigger records a detected error of class 3.
// - Second input low within one second keeps the class at 3.
// - Second input still high after one second raises the class to 4.
// - Inputs are positive logic: high permits operation, low requests torque-off.
// - Only motor winding power is cut; DC bus and supply stay on.
// - No safety-rated brake output is provided by this block.
package dcto_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ            = 25000000;
    localparam int unsigned DISCREPANCY_MS    = 1000;
    localparam int unsigned DISCREPANCY_CYC   = (CLK_HZ / 1000) * DISCREPANCY_MS;
    localparam int unsigned TIMER_W           = 25;

    // ------------------------------------------------------------------
    // Error classes
    // ------------------------------------------------------------------
    localparam logic [2:0]  ERR_CLASS_NONE    = 3'h0;
    localparam logic [2:0]  ERR_CLASS_STOP    = 3'h3;
    localparam logic [2:0]  ERR_CLASS_DISCREP = 3'h4;

    // ------------------------------------------------------------------
    // Monitor states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DCTO_RUN     = 2'b00,
        DCTO_WAIT    = 2'b01,
        DCTO_STOPPED = 2'b10
    } dcto_state_t;

endpackage

// [src/dcto_timer.sv]
/*
 Discrepancy timer: counts enabled cycles and flags when the limit is met.
 Assumes the caller holds clear while it does not need the count.
*/
`timescale 1ns/1ps
module dcto_timer #(
    parameter int unsigned WIDTH = 25,
    parameter int unsigned LIMIT = 25000000
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clear,
    output logic      expired
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    wire              at_limit = (count >= WIDTH'(LIMIT - 1));

    assign next_count = clear ? '0 : (at_limit ? count : count + WIDTH'(1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count   <= '0;
            expired <= 1'b0;
        end
        else
        begin
            count   <= next_count;
            expired <= !clear && at_limit;
        end
    end
endmodule // dcto_timer
